/* File: hdl/tpw_defines.vh */
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define TPW_IDX_TCC_VALUE 6'h01
`define TPW_IDX_TCC_CTRL 6'h07
`define TPW_IDX_WDT_CTRL 6'h08
`define TPW_IDX_CNT_CTRL 6'h09
`define TPW_IDX_PWT_CTRL 6'h0a
`define TPW_IDX_COMMAND 6'h10
`define TPW_IDX_PRESET0 6'h11
`define TPW_IDX_RUN_CTRL 6'h15
`define TPW_IDX_WDT_COUNT 6'h16
`define TPW_IDX_COUNT0 6'h17

// ----------------------------------------
// field positions
// ----------------------------------------
`define TPW_WDT_EN_BIT 3
`define TPW_TCC_SRC_BIT 5
`define TPW_TCC_EDGE_BIT 4
`define TPW_TCC_PSC_BIT 3
`define TPW_CMD_WDT_CLR_BIT 0
`define TPW_CMD_SLEEP_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define TPW_TCC_CTRL_RST 6'h3f
`define TPW_WDT_CTRL_RST 4'h0
`define TPW_CNT_CTRL_RST 8'h00
`define TPW_PWT_CTRL_RST 8'h00

// ----------------------------------------
// operating modes and counts
// ----------------------------------------
`define TPW_MODE_SLEEP 2'h3
`define TPW_WDT_TOP 8'hff

`endif

/* File: hdl/tpw_timer_unit.v */
`timescale 1ns/1ps
// Function
// - watchdog enable bit three switches watchdog
// - watchdog runs from sub-oscillator clock
// - watchdog rate field, 1:1 up to 1:128
// - counter2 source bit seven, sub/main
// - counter2 scale bits 6:4, 1:2 to 1:256
// - counter1 source bit three, sub/main
// - counter1 scale bits 2:0, 1:2 to 1:256
// - low-pulse timer source bit seven
// - low-pulse timer scale bits 6:4
// - high-pulse timer source bit three
// - high-pulse timer scale bits 2:0
// - time counter and watchdog own 8-bit prescalers
// - time counter write clears its prescaler
// - watchdog clear or sleep clears prescaler
// - 8-bit time counter counts instruction cycles
// - external source counts selected pin edges
// - watchdog keeps counting without main oscillator
// - enabled time-out resets device when awake
// - watchdog enable changes take effect immediately
// - time-out is ratio*256 over half sub clock
// - prescale-enable off gives 1:1 time counter
// - time counter source: instruction clock or pin
// - edge select: zero rising, one falling
// - down-counters reload preset after event
`include "tpw_defines.vh"

module tpw_timer_unit (
  // ahb-lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // clock sources, sampled as levels
  input wire sub_oscillator_clock,
  input wire main_oscillator_clock,
  input wire instr_cycle_tick,
  input wire time_counter_pin,
  // core events
  input wire watchdog_clear_instruction,
  input wire sleep_instruction,
  input wire [1:0] op_mode,
  // results
  output reg watchdog_reset_req,
  output reg time_counter_overflow,
  output reg [3:0] timer_event
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // terminal value of a prescaler count; from_two selects the 1:2 based tables
  function [7:0] scale_top;
    input [2:0] code;
    input from_two;
    reg [8:0] ratio;
    begin
      ratio = from_two ? (9'h002 << code) : (9'h001 << code);
      scale_top = ratio[7:0] - 8'h01;
    end
  endfunction

  // true when a bus index selects timer n of a four-entry block
  function idx_is;
    input [5:0] idx;
    input [5:0] base;
    input [1:0] n;
    begin
      idx_is = (idx == base + {4'h0, n});
    end
  endfunction

  // ----------------------------------------
  // bus address phase
  // ----------------------------------------
  // zero wait states: reads are served from the address phase,
  // writes land at the edge that closes their data phase
  reg wr_pend_r;
  reg [5:0] wr_idx_r;
  wire addr_ok = hsel & htrans[1] & hready;
  wire [5:0] a_idx = haddr[7:2];
  wire wr_now = wr_pend_r;
  wire [7:0] wdat = hwdata[7:0];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      wr_idx_r <= a_idx;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg [5:0] tcc_ctrl_r;
  reg [3:0] wdt_ctrl_r;
  reg [7:0] cnt_ctrl_r;
  reg [7:0] pwt_ctrl_r;
  reg [3:0] run_r;
  reg [7:0] preset_r [0:3];
  integer j;

  wire tcc_wr = wr_now & (wr_idx_r == `TPW_IDX_TCC_VALUE);
  wire cmd_wr = wr_now & (wr_idx_r == `TPW_IDX_COMMAND);
  wire wdt_clear = watchdog_clear_instruction | sleep_instruction |
                   (cmd_wr & (wdat[`TPW_CMD_WDT_CLR_BIT] | wdat[`TPW_CMD_SLEEP_BIT]));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcc_ctrl_r <= `TPW_TCC_CTRL_RST;
      wdt_ctrl_r <= `TPW_WDT_CTRL_RST;
      cnt_ctrl_r <= `TPW_CNT_CTRL_RST;
      pwt_ctrl_r <= `TPW_PWT_CTRL_RST;
      run_r <= 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        preset_r[j] <= 8'h00;
      end
    end else if (wr_now) begin
      case (wr_idx_r)
        `TPW_IDX_TCC_CTRL: tcc_ctrl_r <= wdat[5:0];
        `TPW_IDX_WDT_CTRL: wdt_ctrl_r <= wdat[3:0];
        `TPW_IDX_CNT_CTRL: cnt_ctrl_r <= wdat;
        `TPW_IDX_PWT_CTRL: pwt_ctrl_r <= wdat;
        `TPW_IDX_RUN_CTRL: run_r <= wdat[3:0];
        default: begin
          for (j = 0; j < 4; j = j + 1) begin
            if (idx_is(wr_idx_r, `TPW_IDX_PRESET0, j[1:0])) begin
              preset_r[j] <= wdat;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire watchdog_enable_bit = wdt_ctrl_r[`TPW_WDT_EN_BIT];
  wire [2:0] watchdog_rate_select = wdt_ctrl_r[2:0];
  wire time_counter_source_select = tcc_ctrl_r[`TPW_TCC_SRC_BIT];
  wire time_counter_edge_select = tcc_ctrl_r[`TPW_TCC_EDGE_BIT];
  wire time_counter_prescale_on = tcc_ctrl_r[`TPW_TCC_PSC_BIT];
  wire [2:0] time_counter_rate_select = tcc_ctrl_r[2:0];
  wire counter1_source_select = cnt_ctrl_r[3];
  wire [2:0] counter1_scale_select = cnt_ctrl_r[2:0];
  wire counter2_source_select = cnt_ctrl_r[7];
  wire [2:0] counter2_scale_select = cnt_ctrl_r[6:4];
  wire high_pulse_source_select = pwt_ctrl_r[3];
  wire [2:0] high_pulse_scale_select = pwt_ctrl_r[2:0];
  wire low_pulse_source_select = pwt_ctrl_r[7];
  wire [2:0] low_pulse_scale_select = pwt_ctrl_r[6:4];

  // ----------------------------------------
  // source edge detection
  // ----------------------------------------
  // oscillator and pin levels are sampled by hclk, so each must stay
  // high and low for at least one hclk period or edges are lost
  reg sub_prev_r;
  reg main_prev_r;
  reg pin_prev_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_prev_r <= 1'b0;
      main_prev_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      sub_prev_r <= sub_oscillator_clock;
      main_prev_r <= main_oscillator_clock;
      pin_prev_r <= time_counter_pin;
    end
  end

  wire sub_edge = sub_oscillator_clock & ~sub_prev_r;
  wire main_edge = main_oscillator_clock & ~main_prev_r;
  wire pin_rise = time_counter_pin & ~pin_prev_r;
  wire pin_fall = ~time_counter_pin & pin_prev_r;

  // ----------------------------------------
  // time clock counter
  // ----------------------------------------
  reg [7:0] tcc_pre_r;
  reg [7:0] tcc_cnt_r;
  reg tcc_edge_src;

  always @* begin
    if (time_counter_source_select) begin
      tcc_edge_src = time_counter_edge_select ? pin_fall : pin_rise;
    end else begin
      tcc_edge_src = instr_cycle_tick;
    end
  end

  wire [7:0] tcc_top = time_counter_prescale_on ?
                       scale_top(time_counter_rate_select, 1'b1) : 8'h00;
  wire tcc_hit = tcc_edge_src & (tcc_pre_r >= tcc_top);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcc_pre_r <= 8'h00;
      tcc_cnt_r <= 8'h00;
      time_counter_overflow <= 1'b0;
    end else begin
      time_counter_overflow <= 1'b0;
      // a value write both loads the count and restarts the prescaler
      if (tcc_wr) begin
        tcc_pre_r <= 8'h00;
        tcc_cnt_r <= wdat;
      end else if (tcc_hit) begin
        tcc_pre_r <= 8'h00;
        tcc_cnt_r <= tcc_cnt_r + 8'h01;
        time_counter_overflow <= (tcc_cnt_r == 8'hff);
      end else if (tcc_edge_src) begin
        tcc_pre_r <= tcc_pre_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // counts on every second sub-oscillator edge whatever the main oscillator does
  reg wdt_half_r;
  reg [7:0] wdt_pre_r;
  reg [7:0] wdt_cnt_r;
  wire wdt_src = sub_edge & wdt_half_r;
  // the count runs while disabled; enable only gates the reset request,
  // so enabling late can fire soon after unless software clears first
  wire [7:0] wdt_top = scale_top(watchdog_rate_select, 1'b0);
  wire wdt_hit = wdt_src & (wdt_pre_r >= wdt_top);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_half_r <= 1'b0;
      wdt_pre_r <= 8'h00;
      wdt_cnt_r <= 8'h00;
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_reset_req <= 1'b0;
      if (wdt_clear) begin
        wdt_half_r <= 1'b0;
        wdt_pre_r <= 8'h00;
        wdt_cnt_r <= 8'h00;
      end else begin
        if (sub_edge) begin
          wdt_half_r <= ~wdt_half_r;
        end
        if (wdt_hit) begin
          wdt_pre_r <= 8'h00;
          wdt_cnt_r <= wdt_cnt_r + 8'h01;
          // enable is sampled live so a late disable still blocks the reset
          watchdog_reset_req <= (wdt_cnt_r == `TPW_WDT_TOP) &
                                watchdog_enable_bit &
                                (op_mode != `TPW_MODE_SLEEP);
        end else if (wdt_src) begin
          wdt_pre_r <= wdt_pre_r + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // preset down-counters
  // ----------------------------------------
  // index 0 counter1, 1 counter2, 2 high pulse, 3 low pulse
  // a preset write restarts the division period of that timer
  wire [3:0] src_sel = {low_pulse_source_select, high_pulse_source_select,
                        counter2_source_select, counter1_source_select};
  wire [11:0] code_sel = {low_pulse_scale_select, high_pulse_scale_select,
                          counter2_scale_select, counter1_scale_select};
  reg [3:0] act_src_r;
  reg [2:0] act_code_r [0:3];
  reg [7:0] pre_r [0:3];
  reg [7:0] count_r [0:3];
  // per-timer source edge from the select that is in force
  wire [3:0] tick_v;
  integer i;

  assign tick_v[0] = act_src_r[0] ? main_edge : sub_edge;
  assign tick_v[1] = act_src_r[1] ? main_edge : sub_edge;
  assign tick_v[2] = act_src_r[2] ? main_edge : sub_edge;
  assign tick_v[3] = act_src_r[3] ? main_edge : sub_edge;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_src_r <= 4'h0;
      timer_event <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        act_code_r[i] <= 3'h0;
        pre_r[i] <= 8'h00;
        count_r[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        timer_event[i] <= 1'b0;
        if (tick_v[i]) begin
          // a new select is taken only on its old source edge, but pre_r is not cleared,
          // so the first division period after a change can be partial and still emit a pulse
          act_src_r[i] <= src_sel[i];
          act_code_r[i] <= code_sel[3*i +: 3];
        end
        if (wr_now && idx_is(wr_idx_r, `TPW_IDX_PRESET0, i[1:0])) begin
          pre_r[i] <= 8'h00;
          count_r[i] <= wdat;
        end else if (tick_v[i] && pre_r[i] >= scale_top(act_code_r[i], 1'b1)) begin
          pre_r[i] <= 8'h00;
          if (run_r[i]) begin
            if (count_r[i] == 8'h00) begin
              count_r[i] <= preset_r[i];
              timer_event[i] <= 1'b1;
            end else begin
              count_r[i] <= count_r[i] - 8'h01;
            end
          end
        end else if (tick_v[i]) begin
          pre_r[i] <= pre_r[i] + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (a_idx)
      `TPW_IDX_TCC_VALUE: rd_byte = tcc_cnt_r;
      `TPW_IDX_TCC_CTRL: rd_byte = {2'h0, tcc_ctrl_r};
      `TPW_IDX_WDT_CTRL: rd_byte = {4'h0, wdt_ctrl_r};
      `TPW_IDX_CNT_CTRL: rd_byte = cnt_ctrl_r;
      `TPW_IDX_PWT_CTRL: rd_byte = pwt_ctrl_r;
      `TPW_IDX_RUN_CTRL: rd_byte = {4'h0, run_r};
      `TPW_IDX_WDT_COUNT: rd_byte = wdt_cnt_r;
      `TPW_IDX_PRESET0: rd_byte = preset_r[0];
      `TPW_IDX_PRESET0 + 6'h01: rd_byte = preset_r[1];
      `TPW_IDX_PRESET0 + 6'h02: rd_byte = preset_r[2];
      `TPW_IDX_PRESET0 + 6'h03: rd_byte = preset_r[3];
      `TPW_IDX_COUNT0: rd_byte = count_r[0];
      `TPW_IDX_COUNT0 + 6'h01: rd_byte = count_r[1];
      `TPW_IDX_COUNT0 + 6'h02: rd_byte = count_r[2];
      `TPW_IDX_COUNT0 + 6'h03: rd_byte = count_r[3];
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

endmodule

/* File: tb/tpw_timer_unit_properties.sv */
`timescale 1ns/1ps
module tpw_props (
  // bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // events
  input wire watchdog_clear_instruction,
  input wire [1:0] op_mode,
  input wire watchdog_reset_req,
  input wire time_counter_overflow,
  input wire [3:0] timer_event
);
  // ----
  // checks
  // ----
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel & htrans[1] & hready & !hwrite;
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not okay");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_hole; rd && haddr[7:2] == 6'h3f |=> hrdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_slp; watchdog_reset_req |-> $past(op_mode) != 2'h3; endproperty
  a_slp: assert property (p_slp) else $error("reset in sleep");
  property p_wpl; watchdog_reset_req |=> !watchdog_reset_req; endproperty
  a_wpl: assert property (p_wpl) else $error("reset not a pulse");
  property p_clr; watchdog_clear_instruction |=> ##1 !watchdog_reset_req [*4]; endproperty
  a_clr: assert property (p_clr) else $error("reset after clear");
  property p_ovf; time_counter_overflow |=> !time_counter_overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not a pulse");
  property p_evt; |timer_event |=> (timer_event & $past(timer_event)) == 4'h0; endproperty
  a_evt: assert property (p_evt) else $error("event not a pulse");
endmodule
bind tpw_timer_unit tpw_props tpw_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .watchdog_clear_instruction, .op_mode,
  .watchdog_reset_req, .time_counter_overflow, .timer_event);

/* File: tb/tpw_timer_unit_tb_top.sv */
`timescale 1ns/1ps
module tpw_timer_unit_tb_top;
  // ----
  // stimulus
  // ----
  reg hclk = 0;
  reg hresetn = 0;
  reg hwrite = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0, op_mode = 0;
  reg tick = 0, pin = 0, wclr = 0, slp = 0;
  reg [7:0] lfsr = 8'h51, cyc = 0;
  wire hready, ovf, wrq;
  wire [31:0] hrdata;
  wire [3:0] evt;
  integer err_count = 0, compares = 0, ovfs = 0, wdts = 0, j, k, n, n0, m;
  integer evs [0:3] = '{0, 0, 0, 0};
  integer tev [0:3] = '{32, 16, 16, 8};
  reg [5:0] ridx [0:5] = '{6'h07, 6'h08, 6'h09, 6'h0a, 6'h3f, 6'h10};
  reg [7:0] rexp [0:5] = '{8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  reg [7:0] wmsk [0:5] = '{8'h3f, 8'h0f, 8'hff, 8'hff, 8'h00, 8'h00};

  // sub oscillator at an eighth, main at a quarter of the bus clock
  tpw_timer_unit tpw_timer_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
    .sub_oscillator_clock(cyc[2]), .main_oscillator_clock(cyc[1]),
    .instr_cycle_tick(tick), .time_counter_pin(pin), .watchdog_clear_instruction(wclr),
    .sleep_instruction(slp), .op_mode(op_mode), .watchdog_reset_req(wrq),
    .time_counter_overflow(ovf), .timer_event(evt));

  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 8'h01;
    ovfs = ovfs + (ovf === 1'b1);
    wdts = wdts + (wrq === 1'b1);
    for (j = 0; j < 4; j = j + 1) evs[j] = evs[j] + (evt[j] === 1'b1);
  end

  function [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // waits one edge, then until ready is seen
  task wt;
    @(posedge hclk);
    for (n = 0; hready !== 1'b1; n = n + 1) begin
      if (n > 50) begin
        err_count = err_count + 1;
        final_report;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input [5:0] idx, input wr, input [7:0] d);
    haddr <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wt;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt;
    rd = hrdata;
  endtask

  task wd(input [7:0] c, input [1:0] md, input integer lim);
    bus(6'h08, 1'b1, c);
    op_mode <= md;
    wclr <= md != 2'h3;
    slp <= md == 2'h3;
    @(posedge hclk);
    wclr <= 1'b0;
    slp <= 1'b0;
    n0 = wdts;
    for (n = 0; n < lim && wdts == n0; n = n + 1) @(posedge hclk);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 6; k = k + 1) begin
      bus(ridx[k], 1'b0, 8'h00);
      chk("reset value", rd, rexp[k]);
      lfsr = nxt(lfsr);
      bus(ridx[k], 1'b1, lfsr);
      bus(ridx[k], 1'b0, 8'h00);
      chk("read back", rd, lfsr & wmsk[k]);
    end
    // last pass leaves prescale off with rate bits set
    for (k = 0; k < 9; k = k + 1) begin
      bus(6'h07, 1'b1, k == 8 ? 8'h07 : 8'h08 | k);
      bus(6'h01, 1'b1, 8'h10);
      lfsr = nxt(lfsr);
      m = k == 8 ? 1 : 2 << k;
      repeat (2 * (3 * m + lfsr % m)) @(posedge hclk) tick <= ~tick;
      bus(6'h01, 1'b0, 8'h00);
      chk("time count", rd, 32'h13);
    end
    n0 = ovfs;
    bus(6'h01, 1'b1, 8'hff);
    repeat (2) @(posedge hclk) tick <= ~tick;
    repeat (3) @(posedge hclk);
    chk("overflow", ovfs - n0, 1);
    // odd toggle count so the wrong edge gives one less
    for (k = 0; k < 2; k = k + 1) begin
      bus(6'h07, 1'b1, 8'h20 | k << 4);
      bus(6'h01, 1'b1, 8'h00);
      repeat (9) begin
        repeat (2) @(posedge hclk);
        pin <= ~pin;
      end
      repeat (3) @(posedge hclk);
      bus(6'h01, 1'b0, 8'h00);
      chk("pin count", rd, 32'h05);
    end
    bus(6'h09, 1'b1, 8'h98);
    bus(6'h0a, 1'b1, 8'h10);
    for (k = 0; k < 4; k = k + 1) bus(6'h11 + k, 1'b1, 8'h03);
    bus(6'h15, 1'b1, 8'h0f);
    for (k = 0; k < 4; k = k + 1) evs[k] = 0;
    repeat (1024) @(posedge hclk);
    for (k = 0; k < 4; k = k + 1)
      chk("events", (evs[k] >= tev[k] - 1 && evs[k] <= tev[k] + 1) ? tev[k] : evs[k], tev[k]);
    wd(8'h08, 2'h2, 4300);
    chk("wdt period", n > 4070 && n < 4120, 1);
    wd(8'h00, 2'h1, 4300);
    chk("wdt off", n, 4300);
    wd(8'h08, 2'h3, 4300);
    chk("wdt sleep", n, 4300);
    wd(8'h09, 2'h0, 8500);
    chk("wdt rate", n > 8166 && n < 8216, 1);
    final_report;
  end
endmodule
